// [logic/bit_access_consts.svh]
`ifndef BIT_ACCESS_CONSTS_SVH
`define BIT_ACCESS_CONSTS_SVH
// Behaviour
// R1 - read/write bit reads its stored value and takes every written value
// R2 - read-only bit reads hardware value; software writes change nothing
// R3 - write-only bit takes writes; its read value is meaningless
// R4 - write-once bit takes only first write after reset; always readable
// R5 - only reset restores write-once bit and re-arms its single write
// R6 - clear-on-write-one bit clears on written one; zero leaves it
// R7 - clear-on-write-zero bit clears on written zero; one leaves it
// R8 - set-only bit becomes one on written one; zero has no effect
// R9 - clear-on-read bit returns value on read then clears; zero writes ignored
// R10 - software writes reserved bits with reset value only
// R11 - hardware set beats same-cycle software clear of a flag
`define BA_WIDTH_DEFAULT 8
`define BA_RESET_DEFAULT 8'h00
`define BA_WO_READ 1'b0
`define BA_MODE_W 4
`define BA_MODE_RW 4'h0
`define BA_MODE_RO 4'h1
`define BA_MODE_WO 4'h2
`define BA_MODE_RWO 4'h3
`define BA_MODE_W1C 4'h4
`define BA_MODE_W0C 4'h5
`define BA_MODE_SET 4'h6
`define BA_MODE_ROC 4'h7
`define BA_MODE_RES 4'h8
`endif

// [logic/bit_access_pkg.sv]
package bit_access_pkg;
    typedef enum logic [3:0] {
        acc_rw = 4'h0,
        acc_ro = 4'h1,
        acc_wo = 4'h2,
        acc_rwo = 4'h3,
        acc_w1c = 4'h4,
        acc_w0c = 4'h5,
        acc_set = 4'h6,
        acc_roc = 4'h7,
        acc_res = 4'h8
    } access_t;
    typedef struct packed {
        logic wr;
        logic rd;
    } sw_strobe_t;
endpackage : bit_access_pkg

// [logic/register_bit_access.sv]
`timescale 1ns/1ps
`include "bit_access_consts.svh"
module register_bit_access
    import bit_access_pkg::*;
#(
    parameter int WIDTH = `BA_WIDTH_DEFAULT,
    parameter logic [WIDTH-1:0] RESET_VALUE = `BA_RESET_DEFAULT,
    parameter logic [4*WIDTH-1:0] MODES = '0
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire sw_strobe_t sw,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [WIDTH-1:0] hw_value,
    input wire logic [WIDTH-1:0] hw_set,
    output logic [WIDTH-1:0] rdata,
    output logic [WIDTH-1:0] value
);
    // ----------------------------------------------------------------
    // per-bit storage
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] armed;
    logic [WIDTH-1:0] next_value;
    logic [WIDTH-1:0] next_armed;
    logic [WIDTH-1:0] next_rdata;

    function automatic access_t mode_of(input int i);
        mode_of = access_t'(MODES[`BA_MODE_W*i +: `BA_MODE_W]);
    endfunction : mode_of

    // ----------------------------------------------------------------
    // next state: writes, reads and hardware events, bit by bit
    // ----------------------------------------------------------------
    always_comb begin
        next_value = value;
        next_armed = armed;
        next_rdata = rdata;
        if (sw.rd) begin
            next_rdata = value;
        end
        for (int i = 0; i < WIDTH; i++) begin
            case (mode_of(i))
                acc_rw: begin
                    if (sw.wr) next_value[i] = wdata[i]; // R1
                end
                acc_ro: begin
                    next_value[i] = hw_value[i]; // R2
                end
                acc_wo: begin
                    if (sw.wr) next_value[i] = wdata[i]; // R3
                    if (sw.rd) next_rdata[i] = `BA_WO_READ; // R3
                end
                acc_rwo: begin
                    if (sw.wr && armed[i]) begin
                        next_value[i] = wdata[i]; // R4
                        next_armed[i] = 1'b0; // R4
                    end
                end
                acc_w1c: begin
                    if (sw.wr && wdata[i]) next_value[i] = 1'b0; // R6
                    if (hw_set[i]) next_value[i] = 1'b1; // R11
                end
                acc_w0c: begin
                    if (sw.wr && !wdata[i]) next_value[i] = 1'b0; // R7
                    if (hw_set[i]) next_value[i] = 1'b1; // R11
                end
                acc_set: begin
                    if (sw.wr && wdata[i]) next_value[i] = 1'b1; // R8
                end
                acc_roc: begin
                    if (sw.rd) next_value[i] = 1'b0; // R9
                    if (hw_set[i]) next_value[i] = 1'b1; // R11
                end
                acc_res: begin
                    // software is expected to write the reset value back
                    next_value[i] = RESET_VALUE[i]; // R10
                end
                default: begin
                    next_value[i] = value[i];
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            value <= RESET_VALUE; // R5
            armed <= '1; // R5
            rdata <= '0;
        end else begin
            value <= next_value;
            armed <= next_armed;
            rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    for (genvar g = 0; g < WIDTH; g++) begin : g_chk
        if (MODES[`BA_MODE_W*g +: `BA_MODE_W] == `BA_MODE_RW) begin : g_rw
            property p_rw;
                @(posedge clk_sys) disable iff (srst)
                sw.wr |=> value[g] == $past(wdata[g]);
            endproperty
            a_rw: assert property (p_rw) else $error("rw bit missed write"); // R1
            property p_rw_read;
                @(posedge clk_sys) disable iff (srst)
                sw.rd |=> rdata[g] == $past(value[g]);
            endproperty
            a_rw_read: assert property (p_rw_read) else $error("rw bit read wrong"); // R1
        end
        if (MODES[`BA_MODE_W*g +: `BA_MODE_W] == `BA_MODE_RO) begin : g_ro
            property p_ro;
                @(posedge clk_sys) disable iff (srst)
                1'b1 |=> value[g] == $past(hw_value[g]);
            endproperty
            a_ro: assert property (p_ro) else $error("ro bit not hardware value"); // R2
        end
        if (MODES[`BA_MODE_W*g +: `BA_MODE_W] == `BA_MODE_WO) begin : g_wo
            property p_wo;
                @(posedge clk_sys) disable iff (srst)
                sw.rd |=> rdata[g] == `BA_WO_READ;
            endproperty
            a_wo: assert property (p_wo) else $error("wo bit read leaked"); // R3
        end
        if (MODES[`BA_MODE_W*g +: `BA_MODE_W] == `BA_MODE_RWO) begin : g_rwo
            // first write after reset must land and disarm the bit
            sequence s_first_wr;
                sw.wr && armed[g];
            endsequence
            property p_rwo_take;
                @(posedge clk_sys) disable iff (srst)
                s_first_wr |=> value[g] == $past(wdata[g]) && !armed[g];
            endproperty
            a_rwo_take: assert property (p_rwo_take) else $error("rwo first write lost"); // R4
            property p_rwo;
                @(posedge clk_sys) disable iff (srst)
                !armed[g] |=> $stable(value[g]) && !armed[g];
            endproperty
            a_rwo: assert property (p_rwo) else $error("rwo bit rewritten"); // R4
            property p_rwo_rst;
                @(posedge clk_sys) srst |=> armed[g] && value[g] == RESET_VALUE[g];
            endproperty
            a_rwo_rst: assert property (p_rwo_rst) else $error("rwo not re-armed"); // R5
        end
        if (MODES[`BA_MODE_W*g +: `BA_MODE_W] == `BA_MODE_W1C) begin : g_w1c
            sequence s_clr1;
                sw.wr && wdata[g] && !hw_set[g];
            endsequence
            sequence s_keep1;
                sw.wr && !wdata[g] && !hw_set[g];
            endsequence
            property p_w1c_keep;
                @(posedge clk_sys) disable iff (srst)
                s_keep1 |=> $stable(value[g]);
            endproperty
            a_w1c_keep: assert property (p_w1c_keep) else $error("w1c moved on zero"); // R6
            property p_w1c;
                @(posedge clk_sys) disable iff (srst)
                s_clr1 |=> !value[g];
            endproperty
            a_w1c: assert property (p_w1c) else $error("w1c did not clear"); // R6
            property p_w1c_set;
                @(posedge clk_sys) disable iff (srst)
                hw_set[g] |=> value[g];
            endproperty
            a_w1c_set: assert property (p_w1c_set) else $error("set lost"); // R11
        end
        if (MODES[`BA_MODE_W*g +: `BA_MODE_W] == `BA_MODE_W0C) begin : g_w0c
            property p_w0c;
                @(posedge clk_sys) disable iff (srst)
                sw.wr && !wdata[g] && !hw_set[g] |=> !value[g];
            endproperty
            a_w0c: assert property (p_w0c) else $error("w0c did not clear"); // R7
            property p_w0c_keep;
                @(posedge clk_sys) disable iff (srst)
                sw.wr && wdata[g] && !hw_set[g] |=> $stable(value[g]);
            endproperty
            a_w0c_keep: assert property (p_w0c_keep) else $error("w0c moved on one"); // R7
            property p_w0c_set;
                @(posedge clk_sys) disable iff (srst)
                hw_set[g] |=> value[g];
            endproperty
            a_w0c_set: assert property (p_w0c_set) else $error("w0c set lost"); // R11
        end
        if (MODES[`BA_MODE_W*g +: `BA_MODE_W] == `BA_MODE_SET) begin : g_set
            property p_set;
                @(posedge clk_sys) disable iff (srst)
                value[g] |=> value[g];
            endproperty
            a_set: assert property (p_set) else $error("set-only bit fell"); // R8
            property p_set_one;
                @(posedge clk_sys) disable iff (srst)
                sw.wr && wdata[g] |=> value[g];
            endproperty
            a_set_one: assert property (p_set_one) else $error("set-only bit not set"); // R8
        end
        if (MODES[`BA_MODE_W*g +: `BA_MODE_W] == `BA_MODE_ROC) begin : g_roc
            // a read hands out the old value, then the flag drops
            sequence s_rd_clr;
                sw.rd && !hw_set[g];
            endsequence
            property p_roc;
                @(posedge clk_sys) disable iff (srst)
                s_rd_clr |=> !value[g] && rdata[g] == $past(value[g]);
            endproperty
            a_roc: assert property (p_roc) else $error("roc read wrong"); // R9
            property p_roc_keep;
                @(posedge clk_sys) disable iff (srst)
                sw.wr && !wdata[g] && !sw.rd && !hw_set[g] |=> $stable(value[g]);
            endproperty
            a_roc_keep: assert property (p_roc_keep) else $error("roc moved on zero"); // R9
            property p_roc_set;
                @(posedge clk_sys) disable iff (srst)
                hw_set[g] |=> value[g];
            endproperty
            a_roc_set: assert property (p_roc_set) else $error("roc set lost"); // R11
        end
        if (MODES[`BA_MODE_W*g +: `BA_MODE_W] == `BA_MODE_RES) begin : g_res
            property p_res;
                @(posedge clk_sys) disable iff (srst)
                1'b1 |=> value[g] == RESET_VALUE[g];
            endproperty
            a_res: assert property (p_res) else $error("reserved bit moved"); // R10
        end
    end
endmodule : register_bit_access

// [sim/test_register_bit_access.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module test_register_bit_access
    import bit_access_pkg::*;
;
    // ----------------------------------------------------------------
    // one bit per access kind: bit i uses mode i, bit 8 reserved
    // ----------------------------------------------------------------
    localparam logic [35:0] MODES = 36'h876543210;
    // reserved bit 8 resets to one; write-only bit 2 reads carry no meaning
    localparam logic [8:0] RES_KEEP = 9'h100;
    localparam logic [8:0] WO_MASK = 9'h1FB;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    sw_strobe_t sw = '0;
    logic [8:0] wdata = 9'h000;
    logic [8:0] hw_value = 9'h002;
    logic [8:0] hw_set = 9'h000;
    logic [8:0] rdata;
    logic [8:0] value;
    int err_count = 0;
    int checked = 0;
    register_bit_access #(.WIDTH(9), .RESET_VALUE(9'h120), .MODES(MODES)) u_register_bit_access (
        .clk_sys(clk_sys), .srst(srst), .sw(sw), .wdata(wdata), .hw_value(hw_value),
        .hw_set(hw_set), .rdata(rdata), .value(value));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // one-cycle access; strobes and set pulses share the same cycle
    task automatic acc(input logic w, input logic r, input logic [8:0] d, input logic [8:0] hs);
        @(posedge clk_sys) #1;
        sw.wr = w;
        sw.rd = r;
        wdata = d | RES_KEEP;
        hw_set = hs;
        @(posedge clk_sys) #1;
        sw = '0;
        hw_set = 9'h000;
    endtask : acc
    task automatic do_reset;
        srst = 1'b1;
        repeat (6) @(posedge clk_sys);
        #1 srst = 1'b0;
    endtask : do_reset
    task automatic t_after_reset;
        acc(1'b0, 1'b1, 9'h000, 9'h000);
        `CHK(rdata & WO_MASK, 9'h122)
    endtask : t_after_reset
    task automatic t_write_kinds;
        acc(1'b1, 1'b0, 9'h1FF, 9'h000);
        `CHK(value, 9'h16F)
        acc(1'b0, 1'b1, 9'h000, 9'h000);
        `CHK(rdata & WO_MASK, 9'h16B)
        acc(1'b1, 1'b0, 9'h000, 9'h000);
        `CHK(value, 9'h14A)
    endtask : t_write_kinds
    task automatic t_flags;
        acc(1'b0, 1'b0, 9'h000, 9'h0B0);
        `CHK(value, 9'h1FA)
        acc(1'b1, 1'b0, 9'h000, 9'h000);
        `CHK(value, 9'h1DA)
        acc(1'b0, 1'b1, 9'h000, 9'h000);
        `CHK(rdata & WO_MASK, 9'h1DA)
        `CHK(value, 9'h15A)
        acc(1'b1, 1'b0, 9'h010, 9'h000);
        `CHK(value, 9'h14A)
    endtask : t_flags
    task automatic t_set_wins;
        // read, write and set pulses all land together
        acc(1'b1, 1'b1, 9'h010, 9'h0B0);
        `CHK(rdata & WO_MASK, 9'h14A)
        `CHK(value, 9'h1FA)
    endtask : t_set_wins
    task automatic t_rearm;
        hw_value = 9'h000;
        do_reset();
        acc(1'b1, 1'b0, 9'h028, 9'h000);
        `CHK(value, 9'h128)
        acc(1'b1, 1'b0, 9'h002, 9'h000);
        `CHK(value, 9'h108)
    endtask : t_rearm
    task automatic give_verdict;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        // ample margin over some 34 cycles of traffic
        #100us;
        err_count++;
        give_verdict();
    end
    initial begin
        do_reset();
        t_after_reset();
        t_write_kinds();
        t_flags();
        t_set_wins();
        t_rearm();
        give_verdict();
    end
endmodule : test_register_bit_access
